//--- dsps_cmd_seq.sv
/*
 * memory command sequencer: init, refresh, low-power entry and exit.
 * assumes the control side holds sleep_req and wake_req as levels.
 */
module dsps_cmd_seq
    import dsps_pkg::*;
#(
    parameter int INIT_CYC = INIT_WAIT_CYC
) (
    // clock and reset
    input  wire logic   hclk,
    input  wire logic   hresetn,
    // handshake
    dsps_seq_if.seq     hs,
    // memory side
    output dsps_cmd_type sdram_cmd,
    output logic        sdram_cke,
    output logic [2:0]  sdram_cas_latency
);

    initial begin
        if (INIT_CYC < 1 || INIT_CYC > 65535) begin
            $error("dsps_cmd_seq: INIT_CYC out of range");
        end
    end

    typedef enum logic [3:0] {
        S_IDLE, S_INIT_WAIT, S_INIT_PRE, S_INIT_REF1, S_INIT_REF2,
        S_INIT_MODE, S_ENTER, S_LOW, S_EXIT, S_EXIT_WAIT
    } dsps_seq_state_type;

    dsps_seq_state_type st_ff, nxt_st;
    logic [15:0]        cnt_ff, nxt_cnt;
    dsps_cmd_type       cmd_ff, nxt_cmd;
    logic               cke_ff, nxt_cke;
    logic               done_ff, nxt_done;
    logic [2:0]         cas_ff, nxt_cas;
    logic               ack, slp_done, wk_done;

    always_comb begin
        nxt_st   = st_ff;
        nxt_cnt  = cnt_ff;
        nxt_cmd  = CMD_NOP;
        nxt_cke  = cke_ff;
        nxt_done = done_ff;
        nxt_cas  = cas_ff;
        ack      = 1'b0;
        slp_done = 1'b0;
        wk_done  = 1'b0;
        if (cnt_ff != 16'h0000) begin
            nxt_cnt = cnt_ff - 16'h0001;
        end else begin
            case (st_ff)
                S_IDLE: begin
                    if (hs.init_start && !done_ff) begin
                        nxt_st  = S_INIT_WAIT;
                        nxt_cnt = 16'(INIT_CYC);
                    end else if (hs.sleep_req) begin
                        nxt_st = S_ENTER;
                    end else if (hs.ref_due && done_ff) begin
                        nxt_cmd = CMD_AUTO_REFRESH;
                        ack     = 1'b1;
                        nxt_cnt = 16'(CMD_GAP_CYC);
                    end
                end
                S_INIT_WAIT: begin
                    nxt_st = S_INIT_PRE;
                end
                S_INIT_PRE: begin
                    nxt_cmd = CMD_PRECHARGE_ALL;
                    nxt_cnt = 16'(CMD_GAP_CYC);
                    nxt_st  = S_INIT_REF1;
                end
                S_INIT_REF1: begin
                    nxt_cmd = CMD_AUTO_REFRESH;
                    nxt_cnt = 16'(CMD_GAP_CYC);
                    nxt_st  = S_INIT_REF2;
                end
                S_INIT_REF2: begin
                    nxt_cmd = CMD_AUTO_REFRESH;
                    nxt_cnt = 16'(CMD_GAP_CYC);
                    nxt_st  = S_INIT_MODE;
                end
                S_INIT_MODE: begin
                    nxt_cmd  = CMD_LOAD_MODE;
                    nxt_cas  = hs.cas_latency;
                    nxt_cnt  = 16'(CMD_GAP_CYC);
                    nxt_done = 1'b1;
                    nxt_st   = S_IDLE;
                end
                S_ENTER: begin
                    nxt_cmd  = hs.self_refresh_sel ? CMD_SELF_REFRESH
                                                   : CMD_POWER_DOWN;
                    nxt_cke  = 1'b0;
                    slp_done = 1'b1;
                    nxt_st   = S_LOW;
                end
                S_LOW: begin
                    if (hs.wake_req) begin
                        nxt_st = S_EXIT;
                    end
                end
                S_EXIT: begin
                    nxt_cmd = CMD_LOW_POWER_EXIT;
                    nxt_cke = 1'b1;
                    nxt_cnt = 16'(CMD_GAP_CYC);
                    nxt_st  = S_EXIT_WAIT;
                end
                S_EXIT_WAIT: begin
                    wk_done = 1'b1;
                    nxt_st  = S_IDLE;
                end
                default: begin
                    nxt_st = S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff   <= S_IDLE;
            cnt_ff  <= 16'h0000;
            cmd_ff  <= CMD_NOP;
            cke_ff  <= 1'b1;
            done_ff <= 1'b0;
            cas_ff  <= LAT_RST;
        end else begin
            st_ff   <= nxt_st;
            cnt_ff  <= nxt_cnt;
            cmd_ff  <= nxt_cmd;
            cke_ff  <= nxt_cke;
            done_ff <= nxt_done;
            cas_ff  <= nxt_cas;
        end
    end

    assign hs.init_done       = done_ff;
    assign hs.ref_ack         = ack;
    assign hs.sleep_done      = slp_done;
    assign hs.wake_done       = wk_done;
    assign sdram_cmd          = cmd_ff;
    assign sdram_cke          = cke_ff;
    assign sdram_cas_latency  = cas_ff;

endmodule : dsps_cmd_seq

//--- dsps_monitor.sv
/* port assertions for dsps_top.
   assumes one clock, hclk, with async active-low hresetn. */
module dsps_monitor
    import dsps_pkg::*;
(
    // clock and reset
    input wire logic         hclk,
    input wire logic         hresetn,
    // clock gates
    input wire logic         core_clock_en,
    input wire logic         pixel_clock_en,
    input wire logic         memory_clock_en,
    input wire logic         memory_clock_from_osc,
    input wire logic         memory_pll_en,
    // memory side
    input wire logic         bank_four,
    input wire logic [3:0]   row_addr_bits,
    input wire logic [3:0]   col_addr_bits,
    input wire dsps_cmd_type sdram_cmd,
    input wire logic         sdram_cke,
    input wire logic         fetch_enable
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    ////////////////////////////////////////////////////////////////////////
    property p_sleep; !memory_pll_en |-> !core_clock_en && !pixel_clock_en; endproperty
    a_sleep: assert property (p_sleep) else $error("clock on with pll off");
    property p_osc; memory_clock_from_osc |-> memory_clock_en && !pixel_clock_en; endproperty
    a_osc: assert property (p_osc) else $error("bad suspend clocks");
    property p_bank; !bank_four |-> col_addr_bits == 4'h8; endproperty
    a_bank: assert property (p_bank) else $error("columns wide on two banks");
    property p_row; row_addr_bits inside {4'hB, 4'hC, 4'hD}; endproperty
    a_row: assert property (p_row) else $error("row width out of set");
    property p_col; col_addr_bits inside {[4'h8:4'hC]}; endproperty
    a_col: assert property (p_col) else $error("column width out of set");
    property p_lpe; sdram_cmd inside {CMD_POWER_DOWN, CMD_SELF_REFRESH} |-> !sdram_cke; endproperty
    a_lpe: assert property (p_lpe) else $error("cke high after low-power entry");
    property p_cke; !sdram_cke |-> !fetch_enable; endproperty
    a_cke: assert property (p_cke) else $error("fetch while memory asleep");
    property p_gap; sdram_cmd == CMD_LOW_POWER_EXIT |=> !fetch_enable [*3]; endproperty
    a_gap: assert property (p_gap) else $error("fetch too soon after exit");
endmodule : dsps_monitor

bind dsps_top dsps_monitor mon (.*);

//--- dsps_pkg.sv
/*
 * shared constants and types for the display memory configuration and
 * power-state block.
 * assumes a single 40 MHz bus clock that also times the memory commands.
 */
package dsps_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_PWR_CTRL  = 8'hDF;
    localparam logic [7:0] IDX_GEOM_ATTR = 8'hE0;
    localparam logic [7:0] IDX_LAT_MODE  = 8'hE1;
    localparam logic [7:0] IDX_REF_LO    = 8'hE2;
    localparam logic [7:0] IDX_REF_HI    = 8'hE3;
    localparam logic [7:0] IDX_MEM_CTRL  = 8'hE4;
    localparam logic [7:0] IDX_STATUS    = 8'hF0;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int PWR_REQ_BIT    = 7;
    localparam int PWR_MODE_LSB   = 0;
    localparam int ATTR_SR_BIT    = 7;
    localparam int ATTR_BANK_BIT  = 5;
    localparam int ATTR_ROW_LSB   = 3;
    localparam int ATTR_COL_LSB   = 0;
    localparam int LAT_LSB        = 0;
    localparam int CTRL_INIT_BIT  = 0;
    localparam int STAT_INIT_BIT  = 0;
    localparam int STAT_SAVE_BIT  = 1;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [1:0]  PWR_MODE_RST = 2'h3;
    localparam logic [7:0]  GEOM_RST     = 8'h28;
    localparam logic [2:0]  LAT_RST      = 3'h3;
    localparam logic [15:0] REF_RST      = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // encodings
    localparam logic [1:0] MODE_STANDBY = 2'h1;
    localparam logic [1:0] MODE_SUSPEND = 2'h2;
    localparam logic [1:0] MODE_SLEEP   = 2'h3;
    localparam logic [2:0] CAS_TWO      = 3'h2;
    localparam logic [2:0] CAS_THREE    = 3'h3;

    typedef enum logic [2:0] {
        CMD_NOP,
        CMD_PRECHARGE_ALL,
        CMD_AUTO_REFRESH,
        CMD_LOAD_MODE,
        CMD_POWER_DOWN,
        CMD_SELF_REFRESH,
        CMD_LOW_POWER_EXIT
    } dsps_cmd_type;

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_PERIOD_NS  = 25;
    localparam int CMD_GAP_NS     = 100;
    localparam int INIT_WAIT_NS   = 200000;

    function automatic int dsps_ceil_cycles(input int ns);
        dsps_ceil_cycles = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        if (dsps_ceil_cycles < 1) begin
            dsps_ceil_cycles = 1;
        end
    endfunction : dsps_ceil_cycles

    localparam int CMD_GAP_CYC   = dsps_ceil_cycles(CMD_GAP_NS);
    localparam int INIT_WAIT_CYC = dsps_ceil_cycles(INIT_WAIT_NS);

endpackage : dsps_pkg

//--- dsps_refresh_timer.sv
/*
 * auto-refresh interval timer.
 * assumes interval counts hclk cycles, which also clock the memory.
 */
module dsps_refresh_timer
    import dsps_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // clock and reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // control
    input  wire logic             run_en,
    input  wire logic [CNT_W-1:0] interval,
    // handshake
    dsps_seq_if.tmr               hs
);

    initial begin
        if (CNT_W < 2 || CNT_W > 32) begin
            $error("dsps_refresh_timer: CNT_W out of range");
        end
    end

    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic             due_ff;
    logic             nxt_due;

    always_comb begin
        nxt_due = due_ff && !hs.ref_ack;
        if (!run_en || interval == '0) begin
            nxt_cnt = '0;
            nxt_due = 1'b0;
        end else if (cnt_ff >= interval - CNT_W'(1)) begin
            nxt_cnt = '0;
            nxt_due = 1'b1;
        end else begin
            nxt_cnt = cnt_ff + CNT_W'(1);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_ff <= '0;
            due_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            due_ff <= nxt_due;
        end
    end

    assign hs.ref_due = due_ff;

endmodule : dsps_refresh_timer

//--- dsps_sdram_model.sv
/* memory stand-in: counts refreshes, keeps the last low-power entry.
   assumes commands are one-cycle pulses from dsps_top. */
module dsps_sdram_model
    import dsps_pkg::*;
(
    // clock and reset
    input  wire logic         hclk,
    input  wire logic         hresetn,
    // command bus
    input  wire dsps_cmd_type sdram_cmd,
    // observation
    output int                ref_cnt,
    output dsps_cmd_type      lp_cmd,
    output int                bad
);
    logic lp;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_cnt <= 0;
            lp_cmd  <= CMD_NOP;
            bad     <= 0;
            lp      <= 1'b0;
        end else begin
            ref_cnt <= ref_cnt + int'(sdram_cmd == CMD_AUTO_REFRESH);
            bad <= bad + int'(lp && !(sdram_cmd inside {CMD_NOP, CMD_LOW_POWER_EXIT}));
            if (sdram_cmd inside {CMD_POWER_DOWN, CMD_SELF_REFRESH}) begin
                lp     <= 1'b1;
                lp_cmd <= sdram_cmd;
            end
            if (sdram_cmd == CMD_LOW_POWER_EXIT) begin
                lp <= 1'b0;
            end
        end
    end
endmodule : dsps_sdram_model

//--- dsps_seq_if.sv
/*
 * handshake bundle between the power-state control and the memory
 * command sequencer and refresh timer.
 * assumes all parties share hclk.
 */
interface dsps_seq_if;
    import dsps_pkg::*;

    logic       init_start;
    logic       init_done;
    logic       sleep_req;
    logic       self_refresh_sel;
    logic       sleep_done;
    logic       wake_req;
    logic       wake_done;
    logic       ref_due;
    logic       ref_ack;
    logic [2:0] cas_latency;

    modport ctrl (
        output init_start, sleep_req, self_refresh_sel, wake_req, cas_latency,
        input  init_done, sleep_done, wake_done
    );
    modport seq (
        input  init_start, sleep_req, self_refresh_sel, wake_req, cas_latency,
        input  ref_due,
        output init_done, sleep_done, wake_done, ref_ack
    );
    modport tmr (
        input  ref_ack,
        output ref_due
    );
endinterface : dsps_seq_if

//--- dsps_top.sv
/*
 * display memory configuration and power-state control, AHB-Lite slave.
 * assumes a single slave bus (hready equals our hreadyout), word accesses,
 * and memory clocked at hclk rate for refresh counting.
 */
// The AHB-Lite interface to the registers was chosen for this implementation.
// Notes on behaviour
// - writing request bit one enters power saving
// - external, key-scan or software events wake
// - writing zero wakes; bit reads one until resumed
// - mode field picks which clocks stop
// - attribute bit picks power-down or self-refresh
// - bank bit picks two or four banks
// - row field picks 2K, 4K or 8K rows
// - column field picks 256 to 4096 columns with four banks, 256 with two
// - latency field two or three, resets three
// - latency writes ignored after init done
// - refresh interval split low and high bytes
// - auto-refresh each time interval count elapses
// - zero interval disables automatic refresh
// - init flag starts init, reads one, sticks
module dsps_top
    import dsps_pkg::*;
#(
    parameter int INIT_CYC = INIT_WAIT_CYC
) (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // wake sources
    input  wire logic        ext_irq_wake,
    input  wire logic        keyscan_wake,
    // clock control
    output logic             core_clock_en,
    output logic             pixel_clock_en,
    output logic             memory_clock_en,
    output logic             memory_clock_from_osc,
    output logic             memory_pll_en,
    // memory geometry and commands
    output logic             bank_four,
    output logic [3:0]       row_addr_bits,
    output logic [3:0]       col_addr_bits,
    output logic [2:0]       sdram_cas_latency,
    output dsps_cmd_type     sdram_cmd,
    output logic             sdram_cke,
    output logic             fetch_enable
);

    initial begin
        if (INIT_CYC < 1 || INIT_CYC > 65535) begin
            $error("dsps_top: INIT_CYC out of range");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // geometry decode
    function automatic logic [3:0] row_bits_of(input logic [1:0] f);
        row_bits_of = f[1] ? 4'hD : (f[0] ? 4'hC : 4'hB);
    endfunction : row_bits_of

    function automatic logic [3:0] col_bits_of(input logic [2:0] f, input logic four);
        if (!four) begin
            col_bits_of = 4'h8;
        end else if (f[2]) begin
            col_bits_of = 4'hC;
        end else begin
            col_bits_of = 4'h8 + {2'h0, f[1:0]};
        end
    endfunction : col_bits_of

    ////////////////////////////////////////////////////////////////////////
    // state
    typedef enum logic [1:0] {P_RUN, P_ENTER, P_SAVE, P_WAKE} dsps_pwr_type;

    dsps_seq_if hs ();

    dsps_pwr_type pst_ff, nxt_pst;
    logic         req_ff, nxt_req;
    logic         swk_ff, nxt_swk;
    logic [1:0]   mode_ff, nxt_mode;
    logic [1:0]   amode_ff, nxt_amode;
    logic [7:0]   geom_ff, nxt_geom;
    logic [2:0]   lat_ff, nxt_lat;
    logic [15:0]  ref_ff, nxt_ref;
    logic         istart_ff, nxt_istart;
    logic         wpend_ff, nxt_wpend;
    logic [7:0]   widx_ff, nxt_widx;
    logic [31:0]  rdata_ff, nxt_rdata;
    logic [4:0]   clk_ff, nxt_clk;
    logic         wr_now;
    logic [7:0]   wbyte;
    logic [7:0]   aidx;
    logic         rd_take;

    ////////////////////////////////////////////////////////////////////////
    // bus slave: zero wait state, read data registered in address phase
    assign aidx    = haddr[9:2];
    assign rd_take = hsel && hready && htrans[1] && !hwrite;
    assign wr_now  = wpend_ff;
    assign wbyte   = hwdata[7:0];

    always_comb begin
        nxt_wpend = hsel && hready && htrans[1] && hwrite;
        nxt_widx  = nxt_wpend ? aidx : widx_ff;
        nxt_rdata = rdata_ff;
        if (rd_take) begin
            case (aidx)
                IDX_PWR_CTRL:  nxt_rdata = {24'h0, req_ff, 5'h0, mode_ff};
                IDX_GEOM_ATTR: nxt_rdata = {24'h0, geom_ff};
                IDX_LAT_MODE:  nxt_rdata = {29'h0, lat_ff};
                IDX_REF_LO:    nxt_rdata = {24'h0, ref_ff[7:0]};
                IDX_REF_HI:    nxt_rdata = {24'h0, ref_ff[15:8]};
                IDX_MEM_CTRL:  nxt_rdata = {31'h0, hs.init_done};
                IDX_STATUS:    nxt_rdata = {30'h0, pst_ff != P_RUN, hs.init_done};
                default:       nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register writes
    always_comb begin
        nxt_mode   = mode_ff;
        nxt_geom   = geom_ff;
        nxt_lat    = lat_ff;
        nxt_ref    = ref_ff;
        nxt_istart = istart_ff && !hs.init_done;
        if (wr_now) begin
            case (widx_ff)
                IDX_PWR_CTRL:  nxt_mode = wbyte[PWR_MODE_LSB +: 2];
                IDX_GEOM_ATTR: nxt_geom = wbyte & 8'hBF;
                IDX_LAT_MODE: begin
                    if (!hs.init_done && !istart_ff) begin
                        nxt_lat = wbyte[LAT_LSB +: 3];
                    end
                end
                IDX_REF_LO:    nxt_ref[7:0]  = wbyte;
                IDX_REF_HI:    nxt_ref[15:8] = wbyte;
                IDX_MEM_CTRL: begin
                    if (wbyte[CTRL_INIT_BIT] && !hs.init_done) begin
                        nxt_istart = 1'b1;
                    end
                end
                default: begin end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power-state machine
    always_comb begin
        nxt_pst   = pst_ff;
        nxt_req   = req_ff;
        nxt_swk   = swk_ff;
        nxt_amode = amode_ff;
        if (wr_now && widx_ff == IDX_PWR_CTRL) begin
            if (wbyte[PWR_REQ_BIT] && pst_ff == P_RUN) begin
                nxt_req = 1'b1;
            end else if (!wbyte[PWR_REQ_BIT] && req_ff) begin
                nxt_swk = 1'b1;
            end
        end
        case (pst_ff)
            P_RUN: begin
                nxt_swk = nxt_swk && req_ff;
                if (req_ff) begin
                    nxt_amode = mode_ff;
                    nxt_pst   = hs.init_done ? P_ENTER : P_SAVE;
                end
            end
            P_ENTER: begin
                if (hs.sleep_done) begin
                    nxt_pst = P_SAVE;
                end
            end
            P_SAVE: begin
                if (ext_irq_wake || keyscan_wake || swk_ff) begin
                    nxt_pst = P_WAKE;
                end
            end
            P_WAKE: begin
                if (hs.wake_done || !hs.init_done) begin
                    nxt_pst = P_RUN;
                    nxt_req = 1'b0;
                    nxt_swk = 1'b0;
                end
            end
            default: begin
                nxt_pst = P_RUN;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // clock gating: {core, pixel, mem, mem_from_osc, pll}
    always_comb begin
        nxt_clk = 5'h1D;
        if (pst_ff == P_SAVE) begin
            case (amode_ff)
                MODE_SUSPEND: nxt_clk = 5'h06;
                MODE_SLEEP:   nxt_clk = 5'h00;
                default:      nxt_clk = 5'h05;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pst_ff    <= P_RUN;
            req_ff    <= 1'b0;
            swk_ff    <= 1'b0;
            mode_ff   <= PWR_MODE_RST;
            amode_ff  <= PWR_MODE_RST;
            geom_ff   <= GEOM_RST;
            lat_ff    <= LAT_RST;
            ref_ff    <= REF_RST;
            istart_ff <= 1'b0;
            wpend_ff  <= 1'b0;
            widx_ff   <= 8'h00;
            rdata_ff  <= 32'h0000_0000;
            clk_ff    <= 5'h1D;
        end else begin
            pst_ff    <= nxt_pst;
            req_ff    <= nxt_req;
            swk_ff    <= nxt_swk;
            mode_ff   <= nxt_mode;
            amode_ff  <= nxt_amode;
            geom_ff   <= nxt_geom;
            lat_ff    <= nxt_lat;
            ref_ff    <= nxt_ref;
            istart_ff <= nxt_istart;
            wpend_ff  <= nxt_wpend;
            widx_ff   <= nxt_widx;
            rdata_ff  <= nxt_rdata;
            clk_ff    <= nxt_clk;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // handshake and outputs
    assign hs.init_start       = istart_ff;
    assign hs.sleep_req        = pst_ff == P_ENTER;
    assign hs.self_refresh_sel = geom_ff[ATTR_SR_BIT];
    assign hs.wake_req         = pst_ff == P_WAKE;
    assign hs.cas_latency      = lat_ff;

    dsps_cmd_seq #(
        .INIT_CYC (INIT_CYC)
    ) u_seq (
        .hclk              (hclk),
        .hresetn           (hresetn),
        .hs                (hs.seq),
        .sdram_cmd         (sdram_cmd),
        .sdram_cke         (sdram_cke),
        .sdram_cas_latency (sdram_cas_latency)
    );

    dsps_refresh_timer #(
        .CNT_W (16)
    ) u_tmr (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .run_en   (hs.init_done && pst_ff == P_RUN),
        .interval (ref_ff),
        .hs       (hs.tmr)
    );

    assign hreadyout             = 1'b1;
    assign hresp                 = 1'b0;
    assign hrdata                = rdata_ff;
    assign core_clock_en         = clk_ff[4];
    assign pixel_clock_en        = clk_ff[3];
    assign memory_clock_en       = clk_ff[2];
    assign memory_clock_from_osc = clk_ff[1];
    assign memory_pll_en         = clk_ff[0];
    assign bank_four             = geom_ff[ATTR_BANK_BIT];
    assign row_addr_bits         = row_bits_of(geom_ff[ATTR_ROW_LSB +: 2]);
    assign col_addr_bits         = col_bits_of(geom_ff[ATTR_COL_LSB +: 3],
                                               geom_ff[ATTR_BANK_BIT]);
    assign fetch_enable          = hs.init_done && pst_ff == P_RUN;

endmodule : dsps_top

//--- test_display_sdram_config_power_state.sv
/* self-checking bench for dsps_top over ahb-lite.
   assumes dsps_monitor bound and dsps_sdram_model on the command bus. */
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_fail++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module test_display_sdram_config_power_state
    import dsps_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic ext_irq_wake = 1'b0, keyscan_wake = 1'b0, hreadyout, hresp, bank_four;
    logic core_clock_en, pixel_clock_en, memory_clock_en, memory_clock_from_osc;
    logic memory_pll_en, sdram_cke, fetch_enable;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2, sdram_cas_latency;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
    logic [3:0] row_addr_bits, col_addr_bits;
    logic [7:0] v;
    dsps_cmd_type sdram_cmd, lp_cmd;
    int n_fail = 0, compares = 0, ref_cnt, bad, n;
    dsps_top #(.INIT_CYC(20)) dut (.hready(hreadyout), .*);
    dsps_sdram_model sdm (.*);
    always #12.5 hclk = ~hclk;
    ////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        if (n_fail == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out
    task automatic edge_rdy;
        int c = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            if (++c > 50) begin n_fail++; close_out; end
            @(posedge hclk);
        end
    endtask : edge_rdy
    task automatic bus(input logic [7:0] idx, input logic w, input logic [7:0] d);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= w;
        edge_rdy;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        edge_rdy;
        q = hrdata;
    endtask : bus
    task automatic rchk(input logic [7:0] idx, input logic [7:0] e);
        bus(idx, 1'b0, 8'h00);
        `CHK({hresp, q}, {1'b0, 24'h0, e})
    endtask : rchk
    task automatic poll(input logic [7:0] idx, input int b, input logic e);
        for (int k = 0; k < 300; k++) begin
            bus(idx, 1'b0, 8'h00);
            if (q[b] === e) return;
        end
        n_fail++;
        close_out;
    endtask : poll
    function automatic logic [3:0] exp_col(input logic [7:0] a);
        exp_col = !a[5] ? 4'h8 : (a[2] ? 4'hC : 4'h8 + {2'h0, a[1:0]});
    endfunction : exp_col
    ////////////////////////////////////////////////////////////////////////
    initial begin repeat (60000) @(posedge hclk); n_fail++; close_out; end
    initial begin
        void'($urandom(32'hE41C7F87));
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        rchk(IDX_PWR_CTRL, 8'h03);
        rchk(IDX_GEOM_ATTR, 8'h28);
        rchk(IDX_LAT_MODE, 8'h03);
        bus(8'h10, 1'b1, 8'h5A);
        rchk(8'h10, 8'h00);
        for (n = 0; n < 10; n++) begin
            v = (n == 0) ? 8'h00 : (n == 1) ? 8'h3F : 8'($urandom) & 8'hBF;
            bus(IDX_GEOM_ATTR, 1'b1, v);
            rchk(IDX_GEOM_ATTR, v);
            `CHK(row_addr_bits, v[4] ? 4'hD : (v[3] ? 4'hC : 4'hB))
            `CHK({bank_four, col_addr_bits}, {v[5], exp_col(v)})
        end
        bus(IDX_LAT_MODE, 1'b1, 8'h02);
        bus(IDX_MEM_CTRL, 1'b1, 8'h01);
        poll(IDX_STATUS, 0, 1'b1);
        `CHK(sdram_cas_latency, CAS_TWO)
        bus(IDX_LAT_MODE, 1'b1, 8'h03);
        rchk(IDX_LAT_MODE, 8'h02);
        bus(IDX_MEM_CTRL, 1'b1, 8'h00);
        rchk(IDX_MEM_CTRL, 8'h01);
        v = 8'h18 + (8'($urandom) & 8'h0F);
        bus(IDX_REF_LO, 1'b1, v);
        rchk(IDX_REF_LO, v);
        n = ref_cnt;
        repeat (400) @(posedge hclk);
        `CHK(ref_cnt - n >= 400 / (v + 6) && ref_cnt - n <= 400 / v + 1, 1'b1)
        bus(IDX_REF_LO, 1'b1, 8'h00);
        repeat (4) @(posedge hclk);
        n = ref_cnt;
        repeat (400) @(posedge hclk);
        `CHK(ref_cnt - n, 0)
        for (n = 1; n < 4; n++) begin
            bus(IDX_GEOM_ATTR, 1'b1, {n[0], 7'h28});
            bus(IDX_PWR_CTRL, 1'b1, 8'h80 | 8'(n));
            poll(IDX_STATUS, 1, 1'b1);
            for (int k = 0; k < 50 && core_clock_en !== 1'b0; k++) @(posedge hclk);
            `CHK(lp_cmd, n[0] ? CMD_SELF_REFRESH : CMD_POWER_DOWN)
            `CHK({core_clock_en, pixel_clock_en, memory_clock_en}, {2'h0, n != 3})
            `CHK({memory_clock_from_osc, memory_pll_en}, {n == 2, n == 1})
            rchk(IDX_PWR_CTRL, 8'h80 | 8'(n));
            if (n == 1) begin
                bus(IDX_PWR_CTRL, 1'b1, 8'h01);
                rchk(IDX_PWR_CTRL, 8'h81);
            end else begin
                ext_irq_wake <= (n == 2);
                keyscan_wake <= (n == 3);
            end
            poll(IDX_PWR_CTRL, 7, 1'b0);
            ext_irq_wake <= 1'b0;
            keyscan_wake <= 1'b0;
            `CHK({core_clock_en, memory_pll_en, sdram_cke, fetch_enable}, 4'hF)
        end
        `CHK(bad, 0)
        close_out;
    end
endmodule : test_display_sdram_config_power_state
